/* core/smon_seq.sv */
`timescale 1ns/1ps
module smon_seq #(
  parameter logic [15:0] PERIOD_TICKS = 16'h03e8
) (
  input  wire logic                            SYS_CLK,
  input  wire logic                            RST_N,
  input  wire logic                            REG_WE,
  input  wire logic [smon_pkg::ADDR_W-1:0]     REG_ADDR,
  input  wire logic [smon_pkg::DATA_W-1:0]     REG_WDATA,
  output logic      [smon_pkg::DATA_W-1:0]     REG_RDATA,
  input  wire logic [smon_pkg::DATA_W-1:0]     ADC_DATA,
  input  wire logic                            LINK_UP,
  input  wire logic                            BYPASS_FSM,
  output logic                                 ADC_CLK_EN,
  output logic      [smon_pkg::SEL_W-1:0]      SENSOR_SEL,
  output logic                                 SENSOR_RST,
  output logic                                 MON_RST,
  output logic      [smon_pkg::DATA_W-1:0]     ANALOG_TRIM,
  output logic      [smon_pkg::DATA_W-1:0]     DEC_OVERRIDE
);
  import smon_pkg::*;

  typedef struct packed {
    logic [15:0]                  trim_r;
    logic [15:0]                  dec_r;
    logic [SEQ_W-1:0]             seq_r;
    smon_state_t                  st_r;
    logic [SEL_W-1:0]             sensor_r;
    logic [2:0]                   cnt_r;
    logic [ACC_W-1:0]             acc_r;
    logic [15:0]                  wait_r;
    logic [NUM_SENSORS-1:0][15:0] hist_r;
    logic [15:0]                  adc_s1_r;
    logic [15:0]                  adc_s2_r;
    logic                         link_s1_r;
    logic                         link_s2_r;
    logic                         tick_r;
    logic [15:0]                  rdata_r;
    logic [15:0]                  readback_r;
    logic [SEL_W-1:0]             sel_out_r;
    logic                         srst_out_r;
    logic                         mrst_r;
  } smon_regs_t;

  smon_regs_t q;
  smon_regs_t n;
  logic       div_tick;
  logic       launch;
  logic       wr_seq;
  logic [2:0] disc_last;
  logic [2:0] avg_last;

  function automatic logic [15:0] mean_of(input logic [ACC_W-1:0] acc, input logic four);
    mean_of = four ? acc[17:2] : acc[16:1];
  endfunction

  smon_clkdiv u_div (
    .SYS_CLK  (SYS_CLK),
    .RST_N    (RST_N),
    .run      (!q.seq_r[SEQ_HOLD_RESET]),
    .div_code (q.seq_r[SEQ_DIV_HI:SEQ_DIV_LO]),
    .tick     (div_tick)
  );

  always_comb begin
    n         = q;
    launch    = 1'b0;
    wr_seq    = REG_WE && (REG_ADDR == OFS_SEQ_CONTROL);
    disc_last = q.seq_r[SEQ_DISCARD4] ? SAMPLES_4_LAST : SAMPLES_2_LAST;
    avg_last  = q.seq_r[SEQ_AVG4] ? SAMPLES_4_LAST : SAMPLES_2_LAST;

    // converter data and link come from outside this clock
    n.adc_s1_r  = ADC_DATA;
    n.adc_s2_r  = q.adc_s1_r;
    n.link_s1_r = LINK_UP;
    n.link_s2_r = q.link_s1_r;
    n.tick_r    = div_tick;

    if (REG_WE && REG_ADDR == OFS_ANALOG_TRIM) begin
      n.trim_r = REG_WDATA;
    end
    if (REG_WE && REG_ADDR == OFS_DEC_OVERRIDE) begin
      n.dec_r = REG_WDATA;
    end
    if (wr_seq) begin
      n.seq_r[SEQ_W-1:1] = REG_WDATA[SEQ_W-1:1];
    end

    if (q.seq_r[SEQ_HOLD_RESET]) begin
      // held in reset, any run dropped
      n.st_r     = SMON_RESET;
      n.sensor_r = '0;
      n.cnt_r    = '0;
      n.acc_r    = '0;
      n.wait_r   = '0;
    end else begin
      unique case (q.st_r)
        SMON_RESET: begin
          n.st_r = SMON_IDLE;
        end
        SMON_IDLE: begin
          if (!BYPASS_FSM && q.seq_r[SEQ_START] && (q.link_s2_r || q.seq_r[SEQ_RUN_NO_LINK])) begin
            launch     = 1'b1;
            n.st_r     = SMON_DISCARD;
            n.sensor_r = '0;
            n.cnt_r    = '0;
            n.acc_r    = '0;
          end
        end
        SMON_DISCARD: begin
          if (q.tick_r) begin
            if (q.cnt_r == disc_last) begin
              n.cnt_r = '0;
              n.st_r  = SMON_AVG;
            end else begin
              n.cnt_r = q.cnt_r + 3'h1;
            end
          end
        end
        SMON_AVG: begin
          if (q.tick_r) begin
            n.acc_r = q.acc_r + ACC_W'(q.adc_s2_r);
            if (q.cnt_r == avg_last) begin
              n.st_r = SMON_STORE;
            end else begin
              n.cnt_r = q.cnt_r + 3'h1;
            end
          end
        end
        SMON_STORE: begin
          n.hist_r[q.sensor_r] = mean_of(q.acc_r, q.seq_r[SEQ_AVG4]);
          n.cnt_r              = '0;
          n.acc_r              = '0;
          if (q.sensor_r == SEL_W'(NUM_SENSORS - 1)) begin
            n.st_r   = q.seq_r[SEQ_PERIODIC] ? SMON_WAIT : SMON_IDLE;
            n.wait_r = '0;
          end else begin
            n.sensor_r = q.sensor_r + 3'h1;
            n.st_r     = SMON_DISCARD;
          end
        end
        SMON_WAIT: begin
          // periodic bit cleared ends the repetition
          if (!q.seq_r[SEQ_PERIODIC]) begin
            n.st_r = SMON_IDLE;
          end else if (q.tick_r) begin
            if (q.wait_r >= PERIOD_TICKS - 16'h0001) begin
              n.st_r     = SMON_DISCARD;
              n.sensor_r = '0;
            end else begin
              n.wait_r = q.wait_r + 16'h0001;
            end
          end
        end
        default: begin
          n.st_r = SMON_RESET;
        end
      endcase
    end

    // self-clearing start; a new write wins over the clear
    if (wr_seq && REG_WDATA[SEQ_START]) begin
      n.seq_r[SEQ_START] = 1'b1;
    end else if (launch || q.seq_r[SEQ_HOLD_RESET]) begin
      n.seq_r[SEQ_START] = 1'b0;
    end

    // clear applied after the store so it always wins
    if (q.seq_r[SEQ_HIST_CLR]) begin
      n.hist_r = '0;
    end

    if (BYPASS_FSM) begin
      n.sel_out_r  = q.dec_r[DEC_MAN_SEL_HI:DEC_MAN_SEL_LO];
      n.srst_out_r = q.dec_r[DEC_MAN_HOLD];
    end else begin
      n.sel_out_r  = q.sensor_r;
      n.srst_out_r = (q.st_r == SMON_RESET);
    end
    n.mrst_r = (q.st_r == SMON_RESET);

    n.readback_r = q.hist_r[q.dec_r[DEC_RB_SEL_HI:DEC_RB_SEL_LO]];

    unique case (REG_ADDR)
      OFS_ANALOG_TRIM:  n.rdata_r = q.trim_r;
      OFS_DEC_OVERRIDE: n.rdata_r = q.dec_r;
      OFS_SEQ_CONTROL:  n.rdata_r = {7'h00, q.seq_r};
      OFS_READBACK:     n.rdata_r = q.readback_r;
      default:          n.rdata_r = 16'h0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q          <= '0;
      q.trim_r   <= RST_ANALOG_TRIM;
      q.dec_r    <= RST_DEC_OVERRIDE;
      q.seq_r    <= RST_SEQ_CONTROL;
      q.st_r     <= SMON_RESET;
      q.mrst_r   <= 1'b1;
      q.srst_out_r <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign REG_RDATA    = q.rdata_r;
  assign ADC_CLK_EN   = q.tick_r;
  assign SENSOR_SEL   = q.sel_out_r;
  assign SENSOR_RST   = q.srst_out_r;
  assign MON_RST      = q.mrst_r;
  assign ANALOG_TRIM  = q.trim_r;
  assign DEC_OVERRIDE = q.dec_r;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_busy;
    q.st_r inside {SMON_DISCARD, SMON_AVG, SMON_STORE, SMON_WAIT};
  endsequence
  sequence s_last_store;
    q.st_r == SMON_STORE && q.sensor_r == SEL_W'(NUM_SENSORS - 1) && !q.seq_r[SEQ_HOLD_RESET];
  endsequence
  sequence s_fast_gap;
    (!q.tick_r)[*8] ##1 !q.tick_r ##1 q.tick_r;
  endsequence

  AST_HOLD_RESET: assert property (q.seq_r[SEQ_HOLD_RESET] |=> ##1 MON_RST)
    else $error("monitor not in reset while hold bit set");
  AST_ABORT: assert property (s_busy ##0 q.seq_r[SEQ_HOLD_RESET] |=> q.st_r == SMON_RESET)
    else $error("run not aborted by hold-reset");
  AST_ONESHOT: assert property (s_last_store ##0 !q.seq_r[SEQ_PERIODIC] |=> q.st_r == SMON_IDLE)
    else $error("one-shot run did not stop");
  AST_PERIODIC: assert property (s_last_store ##0 q.seq_r[SEQ_PERIODIC] |=> q.st_r == SMON_WAIT)
    else $error("periodic run did not repeat");
  AST_START_CLEAR: assert property (launch && !wr_seq |=> !q.seq_r[SEQ_START] && q.st_r == SMON_DISCARD)
    else $error("start bit not self-cleared on launch");
  AST_LINK_GATE: assert property (q.st_r == SMON_IDLE && !q.link_s2_r && !q.seq_r[SEQ_RUN_NO_LINK]
                                  && !q.seq_r[SEQ_HOLD_RESET] |=> q.st_r == SMON_IDLE)
    else $error("sequencer started without link");
  AST_DISCARD: assert property (q.st_r == SMON_DISCARD && q.tick_r && !q.seq_r[SEQ_HOLD_RESET]
                                && q.cnt_r == (q.seq_r[SEQ_DISCARD4] ? 3'h3 : 3'h1) |=> q.st_r == SMON_AVG)
    else $error("wrong discard count");
  AST_AVG: assert property (q.st_r == SMON_STORE && !q.seq_r[SEQ_HIST_CLR] && !q.seq_r[SEQ_HOLD_RESET]
                            |=> q.hist_r[$past(q.sensor_r)] == mean_of($past(q.acc_r), $past(q.seq_r[SEQ_AVG4])))
    else $error("stored mean wrong");
  AST_DIV_FAST: assert property (disable iff (!RST_N || q.seq_r[SEQ_DIV_HI:SEQ_DIV_LO] != DIV_CODE_FAST
                                 || q.seq_r[SEQ_HOLD_RESET])
                                 q.tick_r |=> s_fast_gap)
    else $error("fast converter rate not ten cycles");
  AST_MAN_SEL: assert property (BYPASS_FSM |=> SENSOR_SEL == $past(q.dec_r[DEC_MAN_SEL_HI:DEC_MAN_SEL_LO]))
    else $error("manual sensor select not applied");
  AST_MAN_HOLD: assert property (BYPASS_FSM |=> SENSOR_RST == $past(q.dec_r[DEC_MAN_HOLD]))
    else $error("manual sensor hold not applied");
  AST_READBACK: assert property (REG_ADDR == OFS_READBACK ##1 REG_ADDR == OFS_READBACK
                                 |=> REG_RDATA == $past(q.readback_r))
    else $error("readback register mismatch");
  AST_HIST_CLR: assert property (q.seq_r[SEQ_HIST_CLR] |=> q.hist_r == '0)
    else $error("history not cleared");

endmodule

/* core/smon_pkg.sv */
package smon_pkg;

  // register port
  localparam int unsigned ADDR_W            = 11;
  localparam int unsigned DATA_W            = 16;
  localparam logic [10:0] OFS_ANALOG_TRIM   = 11'h467;
  localparam logic [10:0] OFS_DEC_OVERRIDE  = 11'h468;
  localparam logic [10:0] OFS_SEQ_CONTROL   = 11'h46a;
  localparam logic [10:0] OFS_READBACK      = 11'h47b;

  localparam logic [15:0] RST_ANALOG_TRIM   = 16'h0012;
  localparam logic [15:0] RST_DEC_OVERRIDE  = 16'h0920;
  localparam logic [8:0]  RST_SEQ_CONTROL   = 9'h094;

  // sequence control fields
  localparam int unsigned SEQ_W             = 9;
  localparam int unsigned SEQ_HIST_CLR      = 8;
  localparam int unsigned SEQ_DISCARD4      = 7;
  localparam int unsigned SEQ_AVG4          = 6;
  localparam int unsigned SEQ_DIV_HI        = 5;
  localparam int unsigned SEQ_DIV_LO        = 4;
  localparam int unsigned SEQ_RUN_NO_LINK   = 3;
  localparam int unsigned SEQ_HOLD_RESET    = 2;
  localparam int unsigned SEQ_PERIODIC      = 1;
  localparam int unsigned SEQ_START         = 0;

  // decimation override fields
  localparam int unsigned DEC_MAN_HOLD      = 15;
  localparam int unsigned DEC_RB_SEL_HI     = 14;
  localparam int unsigned DEC_RB_SEL_LO     = 12;
  localparam int unsigned DEC_MAN_SEL_HI    = 2;
  localparam int unsigned DEC_MAN_SEL_LO    = 0;

  // converter clock: system clock divided by 10, 20 or 40
  localparam int unsigned CLK_FREQ_KHZ      = 125000;
  localparam int unsigned ADC_FAST_KHZ      = 12500;
  localparam logic [5:0]  ADC_DIV_FAST      = 6'(CLK_FREQ_KHZ / ADC_FAST_KHZ);
  localparam logic [1:0]  DIV_CODE_FAST     = 2'h0;
  localparam logic [1:0]  DIV_CODE_MID      = 2'h1;
  localparam logic [1:0]  DIV_CODE_SLOW     = 2'h2;

  // sample counts, stored as count minus one
  localparam logic [2:0]  SAMPLES_2_LAST    = 3'h1;
  localparam logic [2:0]  SAMPLES_4_LAST    = 3'h3;

  localparam int unsigned NUM_SENSORS       = 8;
  localparam int unsigned SEL_W             = 3;
  localparam int unsigned ACC_W             = 18;

  typedef enum logic [2:0] {
    SMON_RESET,
    SMON_IDLE,
    SMON_DISCARD,
    SMON_AVG,
    SMON_STORE,
    SMON_WAIT
  } smon_state_t;

endpackage

/* core/smon_clkdiv.sv */
`timescale 1ns/1ps
module smon_clkdiv (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  input  wire logic       run,
  input  wire logic [1:0] div_code,
  output logic            tick
);
  import smon_pkg::*;

  typedef struct packed {
    logic [5:0] cnt_r;
    logic       tick_r;
  } smon_div_t;

  smon_div_t q;
  smon_div_t n;
  logic [5:0] limit;

  always_comb begin
    n = q;
    // reserved code falls back to the slowest rate
    unique case (div_code)
      DIV_CODE_FAST: limit = ADC_DIV_FAST;
      DIV_CODE_MID:  limit = 6'(ADC_DIV_FAST << 1);
      default:       limit = 6'(ADC_DIV_FAST << 2);
    endcase
    n.tick_r = 1'b0;
    if (!run) begin
      n.cnt_r = '0;
    end else if (q.cnt_r >= limit - 6'h01) begin
      n.cnt_r  = '0;
      n.tick_r = 1'b1;
    end else begin
      n.cnt_r = q.cnt_r + 6'h01;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick_r;

endmodule

/* dv/smon_adc_model.sv */
`timescale 1ns/1ps
module smon_adc_model (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [2:0]  sel,
  input  wire logic        srst,
  output logic      [15:0] data
);
  logic [15:0] held_r;
  logic [3:0]  ramp_r;
  logic [2:0]  sel_d_r;
  initial begin
    held_r  = 16'h0000;
    ramp_r  = 4'h0;
    sel_d_r = 3'h0;
  end
  // held sensor gives no steady value
  always @(posedge clk) begin
    held_r <= ~held_r;
  end
  // ramp counts conversions since the sensor changed, so the mean shows how many were dropped and kept
  always @(posedge clk) begin
    sel_d_r <= sel;
    if (sel != sel_d_r) begin
      ramp_r <= 4'h0;
    end else if (en) begin
      ramp_r <= ramp_r + 4'h1;
    end
  end
  // sensor 0 stays steady: at launch its first conversion may come before the select moves
  assign data = srst ? held_r :
                (16'h0a00 | {9'h000, sel, 4'h0} | ((sel == 3'h0) ? 16'h0000 : {12'h000, ramp_r}));
endmodule

/* dv/smon_seq_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module smon_seq_tb;
  import smon_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        we;
  logic [10:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] adc;
  logic        link;
  logic        byp;
  logic        adc_en;
  logic [2:0]  ssel;
  logic        srst;
  logic        mrst;
  logic [15:0] trim;
  logic [15:0] dec;
  int          errors;
  int          checks_done;
  logic [15:0] v;
  int          n;
  int          k;

  smon_seq #(.PERIOD_TICKS(16'h0004)) smon_seq_i (
    .SYS_CLK(clk), .RST_N(rst_n), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .ADC_DATA(adc), .LINK_UP(link), .BYPASS_FSM(byp),
    .ADC_CLK_EN(adc_en), .SENSOR_SEL(ssel), .SENSOR_RST(srst), .MON_RST(mrst),
    .ANALOG_TRIM(trim), .DEC_OVERRIDE(dec));
  smon_adc_model smon_adc_model_i (.clk(clk), .en(adc_en), .sel(ssel), .srst(srst), .data(adc));

  always #4 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask

  // data is registered, readback adds one more cycle
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    repeat (3) @(posedge clk);
    #1 d = rdata;
  endtask

  task automatic chk_rd(input logic [10:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK("rdata", e, d)
  endtask

  // mean of ramp samples disc .. disc+avg-1, truncated; sensor 0 has no ramp
  function automatic logic [15:0] expv(input int s, input int disc, input int avg);
    int m;
    m = (s == 0) ? 0 : (disc * avg + avg * (avg - 1) / 2) / avg;
    return 16'h0a00 | (16'(s) << 4) | 16'(m);
  endfunction

  task automatic wait_rb(input int s, input logic [15:0] e);
    logic [15:0] d;
    int i;
    wr(OFS_DEC_OVERRIDE, 16'h0920 | (16'(s) << 12));
    d = 16'h0000;
    for (i = 0; i < 500 && d !== e; i++) rd(OFS_READBACK, d);
    if (d !== e) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic gap(output int cnt);
    int i;
    for (i = 0; i < 100 && adc_en !== 1'b1; i++) begin @(posedge clk); #1; end
    cnt = 0;
    do begin @(posedge clk); #1; cnt++; end while (adc_en !== 1'b1 && cnt < 100);
    if (cnt >= 100) begin
      errors++;
      print_verdict();
    end
  endtask

  initial begin
    clk = 1'b0; rst_n = 1'b0; we = 1'b0; addr = 11'h000; wdata = 16'h0000;
    link = 1'b0; byp = 1'b0; errors = 0; checks_done = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1 `CHK("mon_rst", 1'b1, mrst)
    chk_rd(OFS_ANALOG_TRIM, 16'h0012);
    chk_rd(OFS_DEC_OVERRIDE, 16'h0920);
    chk_rd(OFS_SEQ_CONTROL, 16'h0094);
    chk_rd(OFS_READBACK, 16'h0000);
    chk_rd(11'h400, 16'h0000);
    wr(OFS_READBACK, 16'hffff);
    chk_rd(OFS_READBACK, 16'h0000);
    wr(OFS_SEQ_CONTROL, 16'hfe04);
    chk_rd(OFS_SEQ_CONTROL, 16'h0004);
    wr(OFS_ANALOG_TRIM, 16'h5a3c);
    #1 `CHK("trim", 16'h5a3c, trim)
    // converter rate per divider code; reserved code runs at the slowest rate
    for (k = 0; k < 4; k++) begin
      wr(OFS_SEQ_CONTROL, 16'h0080 | (16'(k) << 4));
      gap(n);
      `CHK("tick_gap", 10 << ((k > 2) ? 2 : k), n)
    end
    `CHK("mon_rst", 1'b0, mrst)
    // no link, no force: must not launch
    wr(OFS_SEQ_CONTROL, 16'h0001);
    repeat (400) @(posedge clk);
    wr(OFS_DEC_OVERRIDE, 16'h0920);
    chk_rd(OFS_READBACK, 16'h0000);
    wr(OFS_SEQ_CONTROL, 16'h0009);
    wait_rb(7, expv(7, 2, 2));
    chk_rd(OFS_SEQ_CONTROL, 16'h0008);
    for (k = 0; k < 8; k++) begin
      wr(OFS_DEC_OVERRIDE, 16'h0920 | (16'(k) << 12));
      chk_rd(OFS_READBACK, expv(k, 2, 2));
    end
    // every discard and average setting, link up
    link <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wr(OFS_SEQ_CONTROL, 16'h0100);
      wr(OFS_SEQ_CONTROL, 16'h0000);
      wr(OFS_DEC_OVERRIDE, 16'h0920 | 16'h3000);
      chk_rd(OFS_READBACK, 16'h0000);
      wr(OFS_SEQ_CONTROL, (16'(k) << 6) | 16'h0001);
      wait_rb(7, expv(7, 2 + 2 * (k >> 1), 2 + 2 * (k & 1)));
      wait_rb(3, expv(3, 2 + 2 * (k >> 1), 2 + 2 * (k & 1)));
    end
    // single mode: no refill after clear
    wr(OFS_SEQ_CONTROL, 16'h0100);
    wr(OFS_SEQ_CONTROL, 16'h0000);
    repeat (1000) @(posedge clk);
    wr(OFS_DEC_OVERRIDE, 16'h7920);
    chk_rd(OFS_READBACK, 16'h0000);
    // periodic mode refills by itself
    wr(OFS_SEQ_CONTROL, 16'h0003);
    wait_rb(7, expv(7, 2, 2));
    wr(OFS_SEQ_CONTROL, 16'h0102);
    wr(OFS_SEQ_CONTROL, 16'h0002);
    wait_rb(7, expv(7, 2, 2));
    // hold-reset in mid-run aborts at once
    wr(OFS_SEQ_CONTROL, 16'h0102);
    wr(OFS_SEQ_CONTROL, 16'h0002);
    repeat (60) @(posedge clk);
    wr(OFS_SEQ_CONTROL, 16'h0006);
    repeat (2) @(posedge clk);
    #1 `CHK("mon_rst", 1'b1, mrst)
    repeat (1000) @(posedge clk);
    wr(OFS_DEC_OVERRIDE, 16'h7920);
    chk_rd(OFS_READBACK, 16'h0000);
    // manual override of sensor choice and hold
    wr(OFS_SEQ_CONTROL, 16'h0000);
    byp <= 1'b1;
    wr(OFS_DEC_OVERRIDE, 16'h8005);
    repeat (2) @(posedge clk);
    #1 `CHK("sensor_sel", 3'h5, ssel)
    `CHK("sensor_rst", 1'b1, srst)
    `CHK("dec", 16'h8005, dec)
    wr(OFS_DEC_OVERRIDE, 16'h0003);
    repeat (2) @(posedge clk);
    #1 `CHK("sensor_sel", 3'h3, ssel)
    `CHK("sensor_rst", 1'b0, srst)
    print_verdict();
  end
endmodule
